// file: hw/prot_output_blocking.sv
// Protection output blocking logic with AHB-Lite register slave
//
// Operation
// - Unconfigured release input reads as one
// - Relay block acts only if output configured
// - Isolator or diff alarm blocks when configured
// - Line side CTs transfer, busbar side intertrip
// - Bridged breaker detected and fed into blocking
// - Bay block gates outputs, trips still signalled
// - Mapped bay output blocks breaker failure
// - Relay block freezes protection outputs, raw bay signal passes
// - Conditional retain only when configured blocking
// - Unconditional retain while input is active
// - Zone trip only while release permits
// - Configurable block only when enabled
// - Partial block: busbar trip off, others pass
// - Reset-and-block clears then holds output low
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module prot_output_blocking
    import prot_block_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic                rst_n_i,
    // AHB-Lite slave
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic      [31:0]         hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    // Binary input pins from central and bay units
    input  wire logic                cu_sp_block_i,
    input  wire logic                relay_block_cu_i,
    input  wire logic                relay_block_bu_i,
    input  wire logic                zone_block_i,
    input  wire logic                bbp_block_i,
    input  wire logic                bfp_block_cu_i,
    input  wire logic                bfp_block_bu_i,
    input  wire logic                bp_block_cu_i,
    input  wire logic                bp_block_bu_i,
    input  wire logic                iso_alarm_i,
    input  wire logic                diff_alarm_i,
    input  wire logic                external_zone_release_i,
    input  wire logic                cb_bridged_i,
    // Raw protection function results on the same clock
    input  wire logic                busbar_protection_trip_i,
    input  wire logic                breaker_failure_trip_i,
    input  wire logic                end_fault_trip_i,
    input  wire logic [BP_WIDTH-1:0] bay_protection_raw_i,
    // Blocked protection outputs
    output logic                     zone_trip_output_o,
    output logic                     transfer_trip_o,
    output logic                     busbar_intertrip_o,
    output logic                     zone_blocked_status_o,
    output logic                     sp_blocked_status_o,
    output logic                     isolator_alarm_o,
    output logic                     output_relay_blocked_o,
    output logic [BP_WIDTH-1:0]      bay_protection_out_o,
    output logic [BP_WIDTH-1:0]      bay_protection_signal_o,
    output logic                     bay_prot_blocks_breaker_fail_o,
    output logic                     irq_o
);
    state_t               st_reg;
    state_t               st_next;
    logic [PIN_COUNT-1:0] pins;
    logic                 relay_hold;
    logic                 release_ok;
    logic                 bp_blocked;
    logic                 fresh_trip;
    logic                 addr_take;
    logic [IRQ_WIDTH-1:0] events;

    // Pin levels cross into the clock domain
    pin_sync #(
        .WIDTH (PIN_COUNT)
    ) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({cb_bridged_i, external_zone_release_i, diff_alarm_i, iso_alarm_i,
                     bp_block_bu_i, bp_block_cu_i, bfp_block_bu_i, bfp_block_cu_i,
                     bbp_block_i, zone_block_i, relay_block_bu_i, relay_block_cu_i,
                     cu_sp_block_i}),
        .sync_o    (pins)
    );

    // Read mux for the register file
    function automatic logic [31:0] read_reg(input state_t s, input logic [PIN_COUNT-1:0] p);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (s.addr)
            CFG_OFFSET:        d[CFG_WIDTH-1:0] = s.cfg;
            BFP_MAP_OFFSET:    d[BP_WIDTH-1:0]  = s.bfp_map;
            STATUS_OFFSET:     d = {3'h0, p, 4'h0, s.bp_out, s.bfp_blk, s.relay_out,
                                    s.iso_out, s.sp_blk, s.zone_blk, s.inter, s.xfer, s.trip};
            IRQ_STATUS_OFFSET: d[IRQ_WIDTH-1:0] = s.irq_st;
            IRQ_MASK_OFFSET:   d[IRQ_WIDTH-1:0] = s.irq_mask;
            default:           d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // Blocking conditions from synchronised pins and configuration
    assign relay_hold = (pins[PIN_RELAY_BLOCK_CU] | pins[PIN_RELAY_BLOCK_BU])
                        & st_reg.cfg[CFG_RELAY_BLOCKABLE];
    assign release_ok = st_reg.cfg[CFG_RELEASE_USED] ? pins[PIN_ZONE_RELEASE] : 1'b1;
    assign bp_blocked = pins[PIN_BP_BLOCK_CU] | pins[PIN_BP_BLOCK_BU]
                        | pins[PIN_CB_BRIDGED];
    assign fresh_trip = ((busbar_protection_trip_i & ~pins[PIN_BBP_BLOCK])
                         | breaker_failure_trip_i | end_fault_trip_i)
                        & release_ok;
    assign addr_take  = hsel_i & hready_i & htrans_i[1];
    assign events     = {relay_hold, st_reg.iso_out, st_reg.zone_blk, st_reg.trip};

    // Next state of bus, registers and protection outputs
    always_comb
    begin
        st_next = st_reg;
        // Bus data phase: writes land, reads wait one cycle
        st_next.rd_wait = 1'b0;
        st_next.wr_pend = 1'b0;
        if (st_reg.wr_pend)
        begin
            unique case (st_reg.addr)
                CFG_OFFSET:        st_next.cfg      = hwdata_i[CFG_WIDTH-1:0];
                BFP_MAP_OFFSET:    st_next.bfp_map  = hwdata_i[BP_WIDTH-1:0];
                IRQ_MASK_OFFSET:   st_next.irq_mask = hwdata_i[IRQ_WIDTH-1:0];
                default:           st_next.cfg      = st_reg.cfg;
            endcase
        end
        if (st_reg.rd_wait)
        begin
            st_next.hrdata = read_reg(st_reg, pins);
        end
        if (addr_take)
        begin
            st_next.addr    = haddr_i[7:0];
            st_next.wr_pend = hwrite_i;
            st_next.rd_wait = ~hwrite_i;
        end
        // Sticky events: set wins over write-one-clear
        st_next.ev_prev = events;
        if (st_reg.wr_pend && st_reg.addr == IRQ_STATUS_OFFSET)
        begin
            st_next.irq_st = st_reg.irq_st & ~hwdata_i[IRQ_WIDTH-1:0];
        end
        st_next.irq_st = st_next.irq_st | (events & ~st_reg.ev_prev);
        // Relay block freezes every protection output except the relay blocked status and the raw bay protection signal
        if (!relay_hold)
        begin
            // Zone trip: retain, reset-and-block, else fresh result
            if (pins[PIN_CU_SP_BLOCK])
            begin
                st_next.trip = st_reg.trip;
            end
            else if (pins[PIN_ISO_ALARM])
            begin
                st_next.trip = 1'b0;
            end
            else
            begin
                st_next.trip = fresh_trip;
            end
            // Trip routing by CT side or bridged breaker
            st_next.xfer  = st_next.trip & (st_reg.cfg[CFG_CT_LINE_SIDE] | pins[PIN_CB_BRIDGED]);
            st_next.inter = st_next.trip & ~(st_reg.cfg[CFG_CT_LINE_SIDE] | pins[PIN_CB_BRIDGED]);
            st_next.zone_blk = pins[PIN_CU_SP_BLOCK] | pins[PIN_ZONE_BLOCK] | pins[PIN_BBP_BLOCK]
                               | (pins[PIN_ISO_ALARM] & st_reg.cfg[CFG_ISO_BLOCK_EN])
                               | (pins[PIN_DIFF_ALARM] & st_reg.cfg[CFG_DIFF_BLOCK_EN]);
            st_next.sp_blk  = pins[PIN_CU_SP_BLOCK] | pins[PIN_BBP_BLOCK];
            st_next.iso_out = pins[PIN_ISO_ALARM];
            st_next.bp_out  = bp_blocked ? '0 : bay_protection_raw_i;
            st_next.bfp_blk = pins[PIN_BFP_BLOCK_CU] | pins[PIN_BFP_BLOCK_BU]
                              | (|(bay_protection_raw_i & st_reg.bfp_map));
        end
        st_next.relay_out = relay_hold;
    end

    // State register with synchronous reset
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            st_reg          <= '0;
            st_reg.cfg      <= CFG_RESET;
            st_reg.bfp_map  <= BFP_MAP_RESET;
            st_reg.irq_st   <= IRQ_RESET;
            st_reg.irq_mask <= IRQ_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs from the state register, except hresp_o tied low and the bay protection signal taken straight from the raw input
    assign hrdata_o                       = st_reg.hrdata;
    assign hreadyout_o                    = ~st_reg.rd_wait;
    assign hresp_o                        = 1'b0;
    assign zone_trip_output_o             = st_reg.trip;
    assign transfer_trip_o                = st_reg.xfer;
    assign busbar_intertrip_o             = st_reg.inter;
    assign zone_blocked_status_o          = st_reg.zone_blk;
    assign sp_blocked_status_o            = st_reg.sp_blk;
    assign isolator_alarm_o               = st_reg.iso_out;
    assign output_relay_blocked_o         = st_reg.relay_out;
    assign bay_protection_out_o           = st_reg.bp_out;
    assign bay_protection_signal_o        = bay_protection_raw_i;
    assign bay_prot_blocks_breaker_fail_o = st_reg.bfp_blk;
    assign irq_o                          = |(st_reg.irq_st & st_reg.irq_mask);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // Relay block freezes the zone trip and zone blocked status outputs
    a_relay_hold_freeze: assert property (relay_hold |=> ($stable(st_reg.trip) && $stable(st_reg.zone_blk)))
        else $error("Outputs moved during relay block");

    // Unconfigured relay block has no holding effect
    a_relay_needs_cfg: assert property (!st_reg.cfg[CFG_RELAY_BLOCKABLE] && !pins[PIN_CU_SP_BLOCK]
                                        && pins[PIN_ISO_ALARM] |=> !st_reg.trip)
        else $error("Relay block held an unconfigured output");

    // Central block retains the zone trip
    a_sp_retain_trip: assert property (!relay_hold && pins[PIN_CU_SP_BLOCK] |=> $stable(st_reg.trip))
        else $error("Zone trip changed under central block");

    // Isolator alarm clears the zone trip
    a_iso_clear_trip: assert property (!relay_hold && !pins[PIN_CU_SP_BLOCK] && pins[PIN_ISO_ALARM]
                                       |=> !st_reg.trip)
        else $error("Zone trip not cleared by isolator alarm");

    // Missing release keeps the trip low
    a_release_gate: assert property (!relay_hold && st_reg.cfg[CFG_RELEASE_USED] && !pins[PIN_ZONE_RELEASE]
                                     && !pins[PIN_CU_SP_BLOCK] |=> !st_reg.trip)
        else $error("Trip issued without release");

    // Partial block lets breaker failure through
    a_partial_pass: assert property (!relay_hold && !pins[PIN_CU_SP_BLOCK] && !pins[PIN_ISO_ALARM]
                                     && release_ok && pins[PIN_BBP_BLOCK] && breaker_failure_trip_i
                                     |=> st_reg.trip ##1 1'b1)
        else $error("Breaker failure trip lost under partial block");

    // Configured isolator alarm marks the zone blocked
    a_zone_blk_alarm: assert property (!relay_hold && pins[PIN_ISO_ALARM] && st_reg.cfg[CFG_ISO_BLOCK_EN]
                                       |=> st_reg.zone_blk)
        else $error("Zone blocked status missing for alarm");

    // Busbar block sets the system blocked status
    a_sp_blocked_set: assert property (!relay_hold && pins[PIN_BBP_BLOCK] |=> st_reg.sp_blk)
        else $error("System blocked status missing");

    // Bay block suppresses bay outputs
    a_bay_out_gate: assert property (!relay_hold && bp_blocked |=> (st_reg.bp_out == '0))
        else $error("Bay output passed while blocked");

    // Trip routing follows the CT side setting
    a_trip_routing: assert property (st_reg.trip && st_reg.cfg[CFG_CT_LINE_SIDE] && !relay_hold
                                     && $stable(st_reg.cfg) |-> !st_reg.inter)
        else $error("Intertrip raised with line side CTs");

    // A rising event reaches its sticky bit
    a_irq_sticky: assert property ($rose(st_reg.iso_out) |=> st_reg.irq_st[IRQ_ISO_ALARM])
        else $error("Isolator alarm event not latched");
endmodule

// file: hw/prot_block_pkg.sv
// Register map, field layout and state type of the protection output blocking logic
package prot_block_pkg;

    // Register byte offsets
    localparam logic [7:0] CFG_OFFSET        = 8'h00;
    localparam logic [7:0] BFP_MAP_OFFSET    = 8'h04;
    localparam logic [7:0] STATUS_OFFSET     = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h10;

    // Configuration register field positions
    localparam int CFG_RELAY_BLOCKABLE = 0;
    localparam int CFG_ISO_BLOCK_EN    = 1;
    localparam int CFG_DIFF_BLOCK_EN   = 2;
    localparam int CFG_CT_LINE_SIDE    = 3;
    localparam int CFG_RELEASE_USED    = 4;
    localparam int CFG_WIDTH           = 5;

    // Interrupt event positions
    localparam int IRQ_ZONE_TRIP    = 0;
    localparam int IRQ_ZONE_BLOCKED = 1;
    localparam int IRQ_ISO_ALARM    = 2;
    localparam int IRQ_RELAY_BLOCK  = 3;
    localparam int IRQ_WIDTH        = 4;

    // Number of bay protection output signals
    localparam int BP_WIDTH = 4;

    // Reset values
    localparam logic [CFG_WIDTH-1:0] CFG_RESET     = 5'h00;
    localparam logic [BP_WIDTH-1:0]  BFP_MAP_RESET = 4'h0;
    localparam logic [IRQ_WIDTH-1:0] IRQ_RESET     = 4'h0;

    // Synchronised input pin positions
    localparam int PIN_CU_SP_BLOCK    = 0;
    localparam int PIN_RELAY_BLOCK_CU = 1;
    localparam int PIN_RELAY_BLOCK_BU = 2;
    localparam int PIN_ZONE_BLOCK     = 3;
    localparam int PIN_BBP_BLOCK      = 4;
    localparam int PIN_BFP_BLOCK_CU   = 5;
    localparam int PIN_BFP_BLOCK_BU   = 6;
    localparam int PIN_BP_BLOCK_CU    = 7;
    localparam int PIN_BP_BLOCK_BU    = 8;
    localparam int PIN_ISO_ALARM      = 9;
    localparam int PIN_DIFF_ALARM     = 10;
    localparam int PIN_ZONE_RELEASE   = 11;
    localparam int PIN_CB_BRIDGED     = 12;
    localparam int PIN_COUNT          = 13;

    // Whole state of the blocking block
    typedef struct packed {
        logic [31:0]          hrdata;
        logic                 rd_wait;
        logic                 wr_pend;
        logic [7:0]           addr;
        logic [CFG_WIDTH-1:0] cfg;
        logic [BP_WIDTH-1:0]  bfp_map;
        logic                 trip;
        logic                 xfer;
        logic                 inter;
        logic                 zone_blk;
        logic                 sp_blk;
        logic                 iso_out;
        logic                 relay_out;
        logic [BP_WIDTH-1:0]  bp_out;
        logic                 bfp_blk;
        logic [IRQ_WIDTH-1:0] irq_st;
        logic [IRQ_WIDTH-1:0] irq_mask;
        logic [IRQ_WIDTH-1:0] ev_prev;
    } state_t;

endpackage

// file: hw/pin_sync.sv
// Two flip-flop synchroniser for a vector of independent pin levels
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage read only by the second
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

// file: verification/pin_source.sv
// Binary input pins of central and bay units as seen by the blocking logic
`timescale 1ns/1ns
module pin_source
    import prot_block_pkg::*;
(
    input  wire logic                 slow_i,
    input  wire logic [PIN_COUNT-1:0] want_i,
    output logic      [PIN_COUNT-1:0] pins_o
);
    // Pins move out of phase with the clock, promptly or slowly
    initial
    begin
        pins_o = 13'h0000;
        forever
        begin
            @(want_i);
            pins_o <= #(slow_i ? 7 : 3) want_i;
        end
    end
endmodule

// file: verification/test_protection_output_blocking.sv
// Self-checking bench for the protection output blocking logic
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_protection_output_blocking
    import prot_block_pkg::*;
();
    logic                 clk = 1'h0;
    logic                 rst_n = 1'h0;
    logic                 hsel = 1'h0;
    logic                 hwrite = 1'h0;
    logic [1:0]           htrans = 2'h0;
    logic [31:0]          haddr = 32'h0;
    logic [31:0]          hwdata = 32'h0;
    logic [PIN_COUNT-1:0] want = 13'h0000;
    logic [PIN_COUNT-1:0] pins;
    logic                 slow = 1'h0;
    logic [6:0]           raw = 7'h00;
    logic [31:0]          hrdata, rd;
    logic                 hready, hresp, trip, xfer, inter, zb, spb, iso, relay, breaker_failure_protection, irq;
    logic [BP_WIDTH-1:0]  bay, bsig;
    logic [7:0]           offs [6] = '{CFG_OFFSET, BFP_MAP_OFFSET, STATUS_OFFSET, IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET, 8'h20};
    int                   n_mismatch = 0;
    int                   cmp_count = 0;
    int                   cfg = 0, map = 0, mask = 0, e_irq = 0, prev = 0;
    int                   e_trip = 0, e_x = 0, e_i = 0, e_zb = 0, e_sp = 0, e_iso = 0, e_bay = 0;

    // System clock, 100 MHz
    always #5 clk = ~clk;

    pin_source pin_source_i (.slow_i(slow), .want_i(want), .pins_o(pins));

    prot_output_blocking prot_output_blocking_i (
        .clk_sys_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp),
        .cu_sp_block_i(pins[PIN_CU_SP_BLOCK]), .relay_block_cu_i(pins[PIN_RELAY_BLOCK_CU]),
        .relay_block_bu_i(pins[PIN_RELAY_BLOCK_BU]), .zone_block_i(pins[PIN_ZONE_BLOCK]),
        .bbp_block_i(pins[PIN_BBP_BLOCK]), .bfp_block_cu_i(pins[PIN_BFP_BLOCK_CU]),
        .bfp_block_bu_i(pins[PIN_BFP_BLOCK_BU]), .bp_block_cu_i(pins[PIN_BP_BLOCK_CU]),
        .bp_block_bu_i(pins[PIN_BP_BLOCK_BU]), .iso_alarm_i(pins[PIN_ISO_ALARM]),
        .diff_alarm_i(pins[PIN_DIFF_ALARM]), .external_zone_release_i(pins[PIN_ZONE_RELEASE]),
        .cb_bridged_i(pins[PIN_CB_BRIDGED]), .busbar_protection_trip_i(raw[0]),
        .breaker_failure_trip_i(raw[1]), .end_fault_trip_i(raw[2]), .bay_protection_raw_i(raw[6:3]),
        .zone_trip_output_o(trip), .transfer_trip_o(xfer), .busbar_intertrip_o(inter),
        .zone_blocked_status_o(zb), .sp_blocked_status_o(spb), .isolator_alarm_o(iso),
        .output_relay_blocked_o(relay), .bay_protection_out_o(bay), .bay_protection_signal_o(bsig),
        .bay_prot_blocks_breaker_fail_o(breaker_failure_protection), .irq_o(irq));

    function automatic int pn(input int b);
        return 1 << b;
    endfunction

    // One AHB-Lite single word transfer, waiting on hready at each phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        logic ok;
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do
        begin
            @(negedge clk);
            ok = hready;
            @(posedge clk);
        end
        while (ok !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(negedge clk);
            ok = hready;
            rd = hrdata;
            @(posedge clk);
        end
        while (ok !== 1'h1);
        hsel <= 1'h0;
        `CHK("hresp", 1'h0, hresp)
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'h0, 32'h0);
        `CHK("register", e, rd)
    endtask

    task automatic setc(input int v);
        bus(CFG_OFFSET, 1'h1, 32'(v));
        cfg = v;
    endtask

    // Apply pins and raw results, let them settle, then compare with the model
    task automatic step(input int p, input logic [6:0] r);
        int hold, rel, blk, route;
        @(posedge clk);
        want <= p[PIN_COUNT-1:0];
        raw <= r;
        slow <= 1'($urandom_range(1, 0));
        repeat (6) @(posedge clk);
        hold = (p[PIN_RELAY_BLOCK_CU] | p[PIN_RELAY_BLOCK_BU]) & cfg[CFG_RELAY_BLOCKABLE];
        rel = cfg[CFG_RELEASE_USED] ? p[PIN_ZONE_RELEASE] : 1;
        blk = p[PIN_BP_BLOCK_CU] | p[PIN_BP_BLOCK_BU] | p[PIN_CB_BRIDGED];
        if (hold == 0)
        begin
            if (!p[PIN_CU_SP_BLOCK])
                e_trip = ((r[0] & !p[PIN_BBP_BLOCK]) | r[1] | r[2]) & rel & !p[PIN_ISO_ALARM];
            route = cfg[CFG_CT_LINE_SIDE] | p[PIN_CB_BRIDGED];
            e_x = e_trip & route;
            e_i = e_trip & !route;
            e_zb = p[PIN_CU_SP_BLOCK] | p[PIN_ZONE_BLOCK] | p[PIN_BBP_BLOCK]
                 | (p[PIN_ISO_ALARM] & cfg[CFG_ISO_BLOCK_EN]) | (p[PIN_DIFF_ALARM] & cfg[CFG_DIFF_BLOCK_EN]);
            e_sp = p[PIN_CU_SP_BLOCK] | p[PIN_BBP_BLOCK];
            e_iso = p[PIN_ISO_ALARM];
            e_bay = blk ? 0 : r[6:3];
        end
        e_irq |= (hold * 8 + e_iso * 4 + e_zb * 2 + e_trip) & ~prev;
        prev = hold * 8 + e_iso * 4 + e_zb * 2 + e_trip;
        @(negedge clk);
        `CHK("zone_trip", e_trip[0], trip)
        `CHK("transfer", e_x[0], xfer)
        `CHK("intertrip", e_i[0], inter)
        `CHK("zone_blocked", e_zb[0], zb)
        `CHK("sp_blocked", e_sp[0], spb)
        `CHK("iso_alarm", e_iso[0], iso)
        `CHK("relay_hold", hold[0], relay)
        `CHK("bay_out", e_bay[3:0], bay)
        `CHK("irq", ((e_irq & mask) != 0), irq)
        if (hold == 0)
            `CHK("bay_signal", r[6:3], bsig)
        if (hold == 0 && blk == 0)
            `CHK("bfp_block", ((r[6:3] & map) != 0) | p[PIN_BFP_BLOCK_CU] | p[PIN_BFP_BLOCK_BU], breaker_failure_protection)
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        #500000;
        n_mismatch++;
        close_out();
    end

    // Main sequence
    initial
    begin
        void'($urandom(61));
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        foreach (offs[k])
            rchk(offs[k], 32'h0);
        map = $urandom_range(15, 1);
        mask = $urandom_range(15, 1);
        bus(BFP_MAP_OFFSET, 1'h1, 32'(map));
        bus(IRQ_MASK_OFFSET, 1'h1, 32'(mask));
        bus(CFG_OFFSET, 1'h1, 32'hFFFFFFFF);
        rchk(BFP_MAP_OFFSET, 32'(map));
        rchk(IRQ_MASK_OFFSET, 32'(mask));
        rchk(CFG_OFFSET, 32'h1F);
        $display("test registers done");
        setc(0);
        step(0, 7'h01);
        setc(pn(CFG_RELEASE_USED));
        step(0, 7'h01);
        step(pn(PIN_ZONE_RELEASE), 7'h01);
        setc(0);
        step(pn(PIN_BBP_BLOCK), 7'h01);
        step(pn(PIN_BBP_BLOCK), 7'h02);
        step(pn(PIN_BBP_BLOCK), 7'h04);
        step(0, 7'h01);
        step(pn(PIN_CU_SP_BLOCK), 7'h01);
        step(pn(PIN_CU_SP_BLOCK), 7'h00);
        step(pn(PIN_CU_SP_BLOCK) | pn(PIN_ISO_ALARM), 7'h00);
        step(0, 7'h01);
        step(pn(PIN_ISO_ALARM), 7'h01);
        step(pn(PIN_ISO_ALARM) | pn(PIN_DIFF_ALARM), 7'h00);
        setc(6);
        step(pn(PIN_ISO_ALARM) | pn(PIN_DIFF_ALARM), 7'h00);
        step(pn(PIN_ZONE_BLOCK), 7'h00);
        $display("test zone trip done");
        setc(pn(CFG_CT_LINE_SIDE));
        step(0, 7'h01);
        setc(0);
        step(0, 7'h01);
        step(pn(PIN_CB_BRIDGED), 7'h79);
        rchk(STATUS_OFFSET, 32'h1000_0083);
        repeat (8)
            step(($urandom_range(2, 0) == 0) ? 0 : pn(PIN_BP_BLOCK_CU + $urandom_range(1, 0)), {4'($urandom), 3'h0});
        step(pn(PIN_BFP_BLOCK_CU), 7'h00);
        step(pn(PIN_BFP_BLOCK_BU), 7'h08);
        $display("test bay done");
        step(pn(PIN_RELAY_BLOCK_CU), 7'h01);
        step(0, 7'h00);
        setc(pn(CFG_RELAY_BLOCKABLE));
        step(0, 7'h01);
        step(pn(PIN_RELAY_BLOCK_BU), 7'h01);
        step(pn(PIN_RELAY_BLOCK_BU), 7'h78);
        step(pn(PIN_RELAY_BLOCK_CU) | pn(PIN_ISO_ALARM), 7'h00);
        step(0, 7'h00);
        $display("test relay hold done");
        rchk(IRQ_STATUS_OFFSET, 32'(e_irq));
        bus(IRQ_STATUS_OFFSET, 1'h1, 32'hF);
        e_irq = 0;
        rchk(IRQ_STATUS_OFFSET, 32'h0);
        mask = 15;
        bus(IRQ_MASK_OFFSET, 1'h1, 32'hF);
        step(0, 7'h01);
        rchk(IRQ_STATUS_OFFSET, 32'(e_irq));
        mask = 0;
        bus(IRQ_MASK_OFFSET, 1'h1, 32'h0);
        step(0, 7'h01);
        $display("test interrupts done");
        close_out();
    end
endmodule
